// ===== shared/timer16_pkg.sv
// constants, register map and field layout of the 16-bit timer capture/compare block
// Overview of operation
// - pwm duty set by first compare register
// - pwm active width from its upper 14 bits
// - output control bit 1 picks pwm active level
// - 2^8 basic cycle plus 2^6 sub-cycle
// - clock select bits 6:4 pick count clock
// - output bit 0 enables pin, else port
// - pulse mode: second sets width, first period
// - free run: primary edge captures into second
// - primary edge chosen by edge bits 3:2
// - inputs sampled, two equal samples qualify
// - secondary edge captures into first register
// - opposite primary edge captures into first
// - both-edge primary select blocks opposite-edge capture into first
// - restart: capture, then clear and count on
// - restart edge limited to rising or falling
// - mode field: stop, pwm, free, restart, match
// - match mode: first match clears counter, raises match request
package timer16_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  // word-aligned byte addresses
  localparam logic [ADDR_W-1:0] A_MODE = 6'h00;
  localparam logic [ADDR_W-1:0] A_CCCTL = 6'h04;
  localparam logic [ADDR_W-1:0] A_OUTCTL = 6'h08;
  localparam logic [ADDR_W-1:0] A_CLKSEL = 6'h0C;
  localparam logic [ADDR_W-1:0] A_EDGE = 6'h10;
  localparam logic [ADDR_W-1:0] A_SAMPLE = 6'h14;
  localparam logic [ADDR_W-1:0] A_CC0 = 6'h18;
  localparam logic [ADDR_W-1:0] A_CC1 = 6'h1C;
  localparam logic [ADDR_W-1:0] A_COUNT = 6'h20;
  localparam logic [ADDR_W-1:0] A_STATUS = 6'h24;
  // reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CCCTL = 8'h04;
  localparam logic [7:0] RST_OUTCTL = 8'h00;
  localparam logic [7:0] RST_CLKSEL = 8'h00;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_SAMPLE = 8'h00;
  // field positions
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;
  localparam int CC0_CAP = 0;
  localparam int CC0_SRC = 1;
  localparam int CC1_CAP = 2;
  localparam int OE_BIT = 0;
  localparam int ALV_BIT = 1;
  localparam int CLK_LSB = 4;
  localparam int CLK_MSB = 6;
  localparam int PES_LSB = 2;
  localparam int PES_MSB = 3;
  localparam int SES_LSB = 4;
  localparam int SES_MSB = 5;
  localparam int SCS_MSB = 1;
  localparam int ST_PRIM = 0;
  localparam int ST_SEC = 1;
  localparam int ST_MATCH = 2;
  // pwm split of the 14-bit width
  localparam int PWM_LSB = 2;
  localparam int BASE_LSB = 8;
  localparam int SUB_MSB = 13;
  // edge select, clock select and mode codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [2:0] CLK_EXT = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_PWM = 3'h1;
  localparam logic [1:0] GRP_FREE = 2'h1;
  localparam logic [1:0] GRP_RESTART = 2'h2;
  localparam logic [1:0] GRP_MATCH = 2'h3;
  typedef enum logic [2:0] {M_STOP, M_PWM, M_FREE, M_RESTART, M_MATCH} mode_t;
endpackage : timer16_pkg

// ===== hw/timer16_pwm_ppg_capture.sv
// 16-bit timer with pwm, programmable pulse and pulse-width capture
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps

// sampling noise filter for one trigger pin
module edge_filter (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // sync reset, low active
  input wire logic ce_i, // clock enable
  input wire logic pin_i, // raw pin
  input wire logic sample_i, // sampling strobe
  output logic rise_o, // qualified rising edge
  output logic fall_o // qualified falling edge
);
  logic sync1_q;
  logic sync2_q;
  logic smp_q;
  logic lvl_q;
  logic agree;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // a level counts only after two equal samples in a row
  assign agree = sample_i && (sync2_q == smp_q);
  assign rise_o = agree && sync2_q && !lvl_q;
  assign fall_o = agree && !sync2_q && lvl_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      smp_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (ce_i && sample_i) begin
      smp_q <= sync2_q;
      if (agree) begin
        lvl_q <= sync2_q;
      end
    end
  end
endmodule : edge_filter

module timer16_pwm_ppg_capture (
  input wire logic clk_i, // 50 MHz system clock
  input wire logic rst_n_i, // sync reset, low active
  input wire logic ce_i, // clock enable, freezes all state
  input wire logic [timer16_pkg::ADDR_W-1:0] address_i, // avalon byte address
  input wire logic read_i, // avalon read
  input wire logic write_i, // avalon write
  input wire logic [timer16_pkg::DATA_W-1:0] writedata_i, // avalon write data
  input wire logic [3:0] byteenable_i, // avalon byte enables
  output logic [timer16_pkg::DATA_W-1:0] readdata_o, // avalon read data
  output logic waitrequest_o, // avalon wait
  input wire logic primary_trigger_input_i, // primary pin, async
  input wire logic secondary_trigger_input_i, // secondary pin, async
  output logic timer_output_pin_o, // timer output level
  output logic timer_output_pin_oe_o, // high while timer drives pin
  output logic primary_capture_irq_o, // primary edge request pulse
  output logic secondary_capture_irq_o, // secondary edge request pulse
  output logic match_irq_o // first-register match pulse
);
  import timer16_pkg::*;

  logic [7:0] mode_ctl_q;
  logic [7:0] cc_ctl_q;
  logic [7:0] out_ctl_q;
  logic [7:0] clk_sel_q;
  logic [7:0] edge_mode_q;
  logic [7:0] samp_sel_q;
  logic [CNT_W-1:0] cc0_q;
  logic [CNT_W-1:0] cc1_q;
  logic [CNT_W-1:0] count_q;
  logic [2:0] status_q;
  logic [PRE_W-1:0] pre_q;
  logic wait_q;
  logic run_q;
  logic lv_q;
  mode_t mode;
  logic [2:0] clk_sel;
  logic [1:0] p_sel;
  logic [1:0] s_sel;
  logic [PRE_W-1:0] cmask;
  logic [PRE_W-1:0] smask;
  logic samp_tick;
  logic tick;
  logic p_rise;
  logic p_fall;
  logic s_rise;
  logic s_fall;
  logic p_edge;
  logic p_opp;
  logic s_edge;
  logic capt;
  logic hit0;
  logic hit1;
  logic cap0;
  logic cap1;
  logic wr;
  logic [5:0] sub_rev;
  logic extra;
  logic pwm_act;
  logic [DATA_W-1:0] rdata;

  // merge a write into a 16-bit register under byte enables
  function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old, input logic [DATA_W-1:0] wd,
                                             input logic [3:0] be);
    logic [CNT_W-1:0] r;
    r = old;
    if (be[0]) r[7:0] = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge

  // mode field decode
  always_comb begin
    case (mode_ctl_q[MODE_MSB:MODE_LSB])
      MODE_STOP: mode = M_STOP;
      MODE_PWM: mode = M_PWM;
      default: begin
        case (mode_ctl_q[MODE_MSB:MODE_MSB-1])
          GRP_FREE: mode = M_FREE;
          GRP_RESTART: mode = M_RESTART;
          GRP_MATCH: mode = M_MATCH;
          default: mode = M_STOP;
        endcase
      end
    endcase
  end

  assign clk_sel = clk_sel_q[CLK_MSB:CLK_LSB];
  assign p_sel = edge_mode_q[PES_MSB:PES_LSB];
  assign s_sel = edge_mode_q[SES_MSB:SES_LSB];

  // free prescaler feeds both count clock and sampling strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_q <= '0;
    end else if (ce_i) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // divider 2^(sel-1); sel zero counts qualified primary edges instead
  assign cmask = PRE_W'((9'h001 << (clk_sel - 3'h1)) - 9'h001);
  assign smask = PRE_W'((9'h001 << samp_sel_q[SCS_MSB:0]) - 9'h001);
  assign samp_tick = &(pre_q | ~smask);
  assign tick = (clk_sel == CLK_EXT) ? p_edge : &(pre_q | ~cmask);

  edge_filter u_prim (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(primary_trigger_input_i),
    .sample_i(samp_tick),
    .rise_o(p_rise),
    .fall_o(p_fall)
  );

  edge_filter u_sec (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(secondary_trigger_input_i),
    .sample_i(samp_tick),
    .rise_o(s_rise),
    .fall_o(s_fall)
  );

  // valid edge choice; restart and opposite edge need a single-edge select
  assign p_edge = (p_sel == EDGE_RISE && p_rise) || (p_sel == EDGE_FALL && p_fall) ||
                  (p_sel == EDGE_BOTH && mode != M_RESTART && (p_rise || p_fall));
  assign p_opp = (p_sel == EDGE_RISE && p_fall) || (p_sel == EDGE_FALL && p_rise);
  assign s_edge = (s_sel == EDGE_RISE && s_rise) || (s_sel == EDGE_FALL && s_fall) ||
                  (s_sel == EDGE_BOTH && (s_rise || s_fall));

  assign capt = (mode != M_STOP) && (mode != M_PWM);
  assign hit0 = tick && (count_q == cc0_q);
  assign hit1 = tick && (count_q == cc1_q);
  assign cap1 = capt && cc_ctl_q[CC1_CAP] && p_edge;
  assign cap0 = capt && cc_ctl_q[CC0_CAP] && (cc_ctl_q[CC0_SRC] ? p_opp : s_edge);
  assign wr = write_i && !wait_q;

  // pwm: 8-bit basic cycle, one extra clock spread over a 64-cycle sub-cycle
  assign sub_rev = {<<{count_q[SUB_MSB:BASE_LSB]}};
  assign extra = sub_rev < cc0_q[BASE_LSB-1:PWM_LSB];
  assign pwm_act = {1'b0, count_q[BASE_LSB-1:0]} <
                   ({1'b0, cc0_q[CNT_W-1:BASE_LSB]} + {8'h00, extra});

  // counter: stop clears, restart clears after capture, match wraps
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (ce_i) begin
      if (mode == M_STOP) begin
        count_q <= '0;
      end else if (mode == M_RESTART && p_edge) begin
        count_q <= '0;
      end else if (mode == M_MATCH && hit0) begin
        count_q <= '0;
      end else if (tick) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // compare/capture registers; a capture beats a bus write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cc0_q <= '0;
      cc1_q <= '0;
    end else if (ce_i) begin
      if (cap0) begin
        cc0_q <= count_q;
      end else if (wr && address_i == A_CC0) begin
        cc0_q <= merge(cc0_q, writedata_i, byteenable_i);
      end
      if (cap1) begin
        cc1_q <= count_q;
      end else if (wr && address_i == A_CC1) begin
        cc1_q <= merge(cc1_q, writedata_i, byteenable_i);
      end
    end
  end

  // control registers, low byte only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_ctl_q <= RST_MODE;
      cc_ctl_q <= RST_CCCTL;
      out_ctl_q <= RST_OUTCTL;
      clk_sel_q <= RST_CLKSEL;
      edge_mode_q <= RST_EDGE;
      samp_sel_q <= RST_SAMPLE;
    end else if (ce_i && wr && byteenable_i[0]) begin
      case (address_i)
        A_MODE: mode_ctl_q <= writedata_i[7:0];
        A_CCCTL: cc_ctl_q <= writedata_i[7:0];
        A_OUTCTL: out_ctl_q <= writedata_i[7:0];
        A_CLKSEL: clk_sel_q <= writedata_i[7:0];
        A_EDGE: edge_mode_q <= writedata_i[7:0];
        A_SAMPLE: samp_sel_q <= writedata_i[7:0];
        default: ;
      endcase
    end
  end

  // sticky event flags, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= '0;
    end else if (ce_i) begin
      status_q <= ((wr && address_i == A_STATUS && byteenable_i[0]) ? status_q & ~writedata_i[2:0] : status_q) |
                  {capt && hit0, cap0 && !cc_ctl_q[CC0_SRC], capt && p_edge};
    end
  end

  // request pulses, one clock each
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      primary_capture_irq_o <= 1'b0;
      secondary_capture_irq_o <= 1'b0;
      match_irq_o <= 1'b0;
    end else if (ce_i) begin
      primary_capture_irq_o <= capt && p_edge;
      secondary_capture_irq_o <= cap0 && !cc_ctl_q[CC0_SRC];
      match_irq_o <= capt && hit0;
    end
  end

  // pulse generator level: active from zero, inactive on second match
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      lv_q <= 1'b0;
    end else if (ce_i) begin
      run_q <= mode != M_STOP;
      if (mode == M_STOP) begin
        lv_q <= 1'b0;
      end else if (!run_q || (mode == M_MATCH && hit0)) begin
        lv_q <= 1'b1;
      end else if (hit1) begin
        lv_q <= 1'b0;
      end
    end
  end

  // pin register; disabled output leaves the pin in port mode
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer_output_pin_o <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      timer_output_pin_oe_o <= out_ctl_q[OE_BIT];
      if (mode == M_PWM) begin
        timer_output_pin_o <= pwm_act ^ out_ctl_q[ALV_BIT];
      end else begin
        timer_output_pin_o <= lv_q;
      end
    end
  end

  // read mux
  always_comb begin
    rdata = '0;
    case (address_i)
      A_MODE: rdata[7:0] = mode_ctl_q;
      A_CCCTL: rdata[7:0] = cc_ctl_q;
      A_OUTCTL: rdata[7:0] = out_ctl_q;
      A_CLKSEL: rdata[7:0] = clk_sel_q;
      A_EDGE: rdata[7:0] = edge_mode_q;
      A_SAMPLE: rdata[7:0] = samp_sel_q;
      A_CC0: rdata[CNT_W-1:0] = cc0_q;
      A_CC1: rdata[CNT_W-1:0] = cc1_q;
      A_COUNT: rdata[CNT_W-1:0] = count_q;
      A_STATUS: rdata[2:0] = status_q;
      default: rdata = '0;
    endcase
  end

  // one wait cycle per access keeps readdata registered
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
      readdata_o <= '0;
    end else if (ce_i) begin
      wait_q <= !((read_i || write_i) && wait_q);
      if (read_i && wait_q) begin
        readdata_o <= rdata;
      end
    end
  end
  assign waitrequest_o = wait_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_stop_clears_count: assert property (ce_i && mode == M_STOP |=> count_q == '0)
    else $error("count not cleared in stop");
  a_second_capture: assert property (ce_i && cap1 |=> cc1_q == $past(count_q) && primary_capture_irq_o)
    else $error("second register capture wrong");
  a_restart_clear: assert property (ce_i && mode == M_RESTART && p_edge |=> count_q == '0)
    else $error("restart did not clear counter");
  a_match_wrap: assert property (ce_i && mode == M_MATCH && hit0 |=> count_q == '0 && match_irq_o)
    else $error("match did not wrap counter");
  a_secondary_capture: assert property (ce_i && cap0 && !cc_ctl_q[CC0_SRC] |=>
      cc0_q == $past(count_q) && secondary_capture_irq_o)
    else $error("secondary capture wrong");
  a_both_no_capture: assert property (ce_i && cc_ctl_q[CC0_CAP] && cc_ctl_q[CC0_SRC] && p_sel == EDGE_BOTH &&
      !(wr && address_i == A_CC0) |=> $stable(cc0_q))
    else $error("first register captured on both edges");
  a_pwm_pin_level: assert property (ce_i && mode == M_PWM |=>
      timer_output_pin_o == ($past(pwm_act) ^ $past(out_ctl_q[ALV_BIT])))
    else $error("pwm pin level wrong");
  a_port_mode: assert property (ce_i && !out_ctl_q[OE_BIT] |=> !timer_output_pin_oe_o)
    else $error("pin driven while disabled");
  a_ppg_inactive: assert property (ce_i && run_q && mode == M_MATCH && hit1 && !hit0 |=> !lv_q)
    else $error("pulse not ended on second match");
  a_filter_two: assert property (ce_i && !samp_tick |=> !primary_capture_irq_o)
    else $error("primary request without sampling strobe");
  a_restart_single: assert property (ce_i && mode == M_RESTART && p_sel == EDGE_BOTH |=>
      !primary_capture_irq_o)
    else $error("restart taken on both edges");
endmodule : timer16_pwm_ppg_capture

// ===== verification/far_side_model.sv
// far-side model: trigger pulse sources and a low-pass integrator on the timer pin
`timescale 1ns/100ps
module far_side_model (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // sync reset, low active
  input wire logic prim_lvl_i, // wanted primary level
  input wire logic sec_lvl_i, // wanted secondary level
  input wire logic pin_i, // timer output level
  input wire logic pin_oe_i, // timer drives pin
  input wire logic clr_i, // clear integrator
  input wire logic en_i, // integrate
  output logic prim_o, // primary trigger pin
  output logic sec_o, // secondary trigger pin
  output logic [15:0] act_o // high cycles seen
);
  // sources re-time the wanted levels like a slow external driver
  always_ff @(posedge clk_i) begin
    prim_o <= prim_lvl_i;
    sec_o <= sec_lvl_i;
  end
  // port mode leaves the pin undriven, so it adds nothing to the filter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clr_i) begin
      act_o <= 16'h0000;
    end else if (en_i && pin_oe_i && pin_i === 1'b1) begin
      act_o <= act_o + 16'h0001;
    end
  end
endmodule : far_side_model

// ===== verification/timer16_pwm_ppg_capture_tb.sv
// self-checking bench for the 16-bit timer block
`timescale 1ns/100ps
module timer16_pwm_ppg_capture_tb;
  import timer16_pkg::*;
  logic clk_i, rst_n_i, read_i, write_i, wrq, plv, slv, clr, en, pin, oe, pirq, sirq, mirq, prim, sec;
  logic [ADDR_W-1:0] address_i;
  logic [DATA_W-1:0] writedata_i, rdata, rd;
  logic [15:0] seed, act, a, b, w;
  int mismatches, samples_checked, np, ns, nm, s0, n, hi, per;
  logic [ADDR_W-1:0] ra [10] = '{A_MODE, A_CCCTL, A_OUTCTL, A_CLKSEL, A_EDGE, A_SAMPLE, A_CC0, A_CC1, A_COUNT, 6'h3C};
  logic [7:0] re [10] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [1:0] ec [4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, 2'h2};
  int ne [4] = '{1, 1, 2, 0};

  timer16_pwm_ppg_capture u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF), .readdata_o(rdata),
    .waitrequest_o(wrq), .primary_trigger_input_i(prim), .secondary_trigger_input_i(sec),
    .timer_output_pin_o(pin), .timer_output_pin_oe_o(oe), .primary_capture_irq_o(pirq),
    .secondary_capture_irq_o(sirq), .match_irq_o(mirq));
  far_side_model u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .prim_lvl_i(plv), .sec_lvl_i(slv), .pin_i(pin),
    .pin_oe_i(oe), .clr_i(clr), .en_i(en), .prim_o(prim), .sec_o(sec), .act_o(act));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // request tallies; scenarios compare against a snapshot
  always @(posedge clk_i) begin
    np <= np + (pirq === 1'b1);
    ns <= ns + (sirq === 1'b1);
    nm <= nm + (mirq === 1'b1);
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // one avalon access; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    address_i <= ad;
    writedata_i <= d;
    read_i <= ~wr;
    write_i <= wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (wrq !== 1'b0 && k < 50);
    rd = rdata;
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (k >= 50) begin
      mismatches++;
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    bus(1'b1, ad, d);
  endtask : wr

  task automatic rd16(input logic [ADDR_W-1:0] ad, output logic [15:0] v);
    bus(1'b0, ad, 32'h0);
    v = rd[15:0];
  endtask : rd16

  task automatic pulse(input int hw, input int gap);
    plv <= 1'b1;
    repeat (hw) @(posedge clk_i);
    plv <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask : pulse

  // bounded wait for a pin level, counting cycles
  task automatic wait_pin(input logic v, output int c);
    c = 0;
    while (pin !== v && c < 2000) begin
      @(posedge clk_i);
      c++;
    end
    if (c >= 2000) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_pin

  initial begin
    rst_n_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = '0;
    writedata_i = '0;
    plv = 1'b0;
    slv = 1'b0;
    clr = 1'b1;
    en = 1'b0;
    seed = 16'h002D;
    mismatches = 0;
    samples_checked = 0;
    np = 0;
    ns = 0;
    nm = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // reset values, unmapped hole last
    for (int i = 0; i < 10; i++) begin
      rd16(ra[i], a);
      check_val(a, re[i]);
    end
    check_val(oe, 32'h0);
    // pwm: random duty, random duty active low, full-scale duty
    wr(A_CLKSEL, 32'h10);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      w = (k == 2) ? 16'hFFFC : (seed & 16'hFFFC);
      wr(A_MODE, 32'h02);
      wr(A_OUTCTL, (k == 1) ? 32'h03 : 32'h01);
      wr(A_CC0, {16'h0, w});
      repeat (8) @(posedge clk_i);
      clr <= 1'b0;
      en <= 1'b1;
      repeat (16384) @(posedge clk_i);
      en <= 1'b0;
      @(posedge clk_i);
      check_val(act, (k == 1) ? 16384 - w[15:2] : w[15:2]);
      check_val(oe, 32'h1);
      clr <= 1'b1;
    end
    wr(A_OUTCTL, 32'h00);
    repeat (2) @(posedge clk_i);
    check_val(oe, 32'h0);
    // programmable pulse: width from second register, period from first
    wr(A_MODE, 32'h00);
    rd16(A_COUNT, a);
    check_val(a, 32'h0);
    seed = lfsr(seed);
    a = 16'd40 + seed[5:0];
    b = 16'd1 + seed[10:6];
    wr(A_CCCTL, 32'h00);
    wr(A_CC0, {16'h0, a});
    wr(A_CC1, {16'h0, b});
    wr(A_OUTCTL, 32'h01);
    wr(A_MODE, 32'h0C);
    wait_pin(1'b1, n);
    wait_pin(1'b0, n);
    wait_pin(1'b1, n);
    s0 = nm;
    wait_pin(1'b0, hi);
    wait_pin(1'b1, per);
    check_val(hi, b + 16'd1);
    check_val(hi + per, a + 1);
    check_val(nm - s0, 32'h1);
    // only the match flag can have been raised since reset
    rd16(A_STATUS, a);
    check_val(a, 32'h4);
    // captures on a free-running counter, sampling every clock
    wr(A_MODE, 32'h04);
    wr(A_SAMPLE, 32'h00);
    for (int k = 0; k < 4; k++) begin
      wr(A_EDGE, {28'h0, ec[k], 2'b00});
      wr(A_CCCTL, 32'h04);
      s0 = np;
      pulse(10, 40);
      check_val(np - s0, ne[k]);
    end
    seed = lfsr(seed);
    w = 16'd20 + seed[5:0];
    wr(A_EDGE, 32'h04);
    wr(A_CCCTL, 32'h07);
    pulse(w, 40);
    rd16(A_CC0, a);
    rd16(A_CC1, b);
    check_val({16'h0, a - b}, w);
    wr(A_CC0, 32'h1234);
    wr(A_EDGE, 32'h0C);
    s0 = np;
    pulse(w, 40);
    rd16(A_CC0, a);
    check_val(a, 32'h1234);
    check_val(np - s0, 32'h2);
    // secondary pin captures into the first register
    wr(A_CCCTL, 32'h05);
    wr(A_EDGE, 32'h14);
    s0 = ns;
    plv <= 1'b1;
    repeat (w) @(posedge clk_i);
    slv <= 1'b1;
    repeat (40) @(posedge clk_i);
    plv <= 1'b0;
    slv <= 1'b0;
    repeat (40) @(posedge clk_i);
    rd16(A_CC0, a);
    rd16(A_CC1, b);
    check_val({16'h0, a - b}, w);
    check_val(ns - s0, 32'h1);
    // noise shorter than a sampling period is rejected
    wr(A_SAMPLE, 32'h02);
    wr(A_EDGE, 32'h04);
    wr(A_CCCTL, 32'h04);
    s0 = np;
    pulse(2, 40);
    check_val(np - s0, 32'h0);
    pulse(16, 40);
    check_val(np - s0, 32'h1);
    wr(A_SAMPLE, 32'h00);
    // restart: second interval longer by w plus the three clocks of the read
    wr(A_MODE, 32'h08);
    seed = lfsr(seed);
    w = 16'd10 + seed[4:0];
    pulse(5, 55);
    pulse(5, 55 + w);
    rd16(A_CC1, a);
    pulse(5, 100);
    rd16(A_CC1, b);
    check_val({16'h0, b - a}, w + 16'd3);
    // both-edge select gives restart no valid edge
    wr(A_EDGE, 32'h0C);
    s0 = np;
    pulse(5, 40);
    check_val(np - s0, 32'h0);
    wr(A_EDGE, 32'h04);
    // count clock dividers, then counting of qualified primary edges
    wr(A_MODE, 32'h04);
    for (int s = 1; s < 5; s++) begin
      wr(A_CLKSEL, s << 4);
      rd16(A_COUNT, a);
      repeat (398) @(posedge clk_i);
      rd16(A_COUNT, b);
      n = 16'(b - a);
      check_val(n >= (400 >> (s - 1)) - 1 && n <= (400 >> (s - 1)) + 1, 32'h1);
    end
    wr(A_CLKSEL, 32'h00);
    rd16(A_COUNT, a);
    repeat (5) pulse(6, 20);
    rd16(A_COUNT, b);
    check_val({16'h0, b - a}, 32'h5);
    complete_run();
  end
endmodule : timer16_pwm_ppg_capture_tb
